// file: verilog/chirp_nco_quadrature_mixer.sv
// Chirp-capable phase generator, sine/cosine stage and quadrature mixer.
// Assumes samples and bus strobes are synchronous to clk; reads answer next cycle.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

module chirp_nco_quadrature_mixer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [15:0] sample_input_bus,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic      [16:0] i_out,
  output logic      [16:0] q_out,
  output logic      [17:0] phase_word
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [17:0]         offset;
    logic [31:0]         min_inc;
    logic [31:0]         max_inc;
    logic [23:0]         delta;
    nco_mixer_pkg::mode_e mode;
    logic                offbin;
    logic                load;
    logic                dir_down;
    logic [32:0]         acc;
    logic [31:0]         inc;
    logic [15:0]         sample;
    logic [15:0]         cos_v;
    logic [15:0]         sin_v;
    logic [16:0]         i_mix;
    logic [16:0]         q_mix;
    logic [31:0]         rdata;
  } state_s;

  localparam state_s ST_RESET = '{
    offset:   nco_mixer_pkg::RST_OFFSET,
    min_inc:  nco_mixer_pkg::RST_MIN,
    max_inc:  nco_mixer_pkg::RST_MAX,
    delta:    nco_mixer_pkg::RST_DELTA,
    mode:     nco_mixer_pkg::constant_tone_mode,
    offbin:   nco_mixer_pkg::RST_OFFBIN,
    load:     1'b1,
    default:  '0
  };

  state_s      st;
  state_s      next_st;
  logic [32:0] cand_up;
  logic [32:0] cand_dn;
  logic        dn_floor;

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] parab_sine(input logic [17:0] p);
    logic [17:0] x;
    logic [35:0] prod;
    logic [15:0] mag;
    x    = {1'b0, p[16:0]};
    prod = {18'h0, x} * {18'h0, nco_mixer_pkg::HALF_SPAN - x};
    mag  = prod[33:18];
    return p[17] ? 16'h0 - mag : mag;
  endfunction

  function automatic logic [16:0] round17(input logic [31:0] v);
    logic [31:0] b;
    b = v + (v[31] ? nco_mixer_pkg::RND_NEG : nco_mixer_pkg::RND_POS);
    return b[31:15];
  endfunction

  function automatic logic restart_hit(input logic w, input logic [3:0] a, input logic [31:0] d);
    return w && a == nco_mixer_pkg::REG_CTRL && d[nco_mixer_pkg::CTRL_RESTART_BIT];
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    next_st  = st;
    cand_up  = {1'b0, st.inc} + {9'h0, st.delta};
    cand_dn  = {1'b0, st.inc} - {9'h0, st.delta};
    dn_floor = cand_dn[32] || (cand_dn[31:0] < st.min_inc);
    next_st.rdata = 32'h0;

    // Register writes
    if (wr) begin
      unique case (addr)
        nco_mixer_pkg::REG_CTRL: begin
          next_st.mode   = nco_mixer_pkg::mode_e'(wdata[nco_mixer_pkg::CTRL_MODE_LSB +: 2]);
          next_st.offbin = wdata[nco_mixer_pkg::CTRL_OFFBIN_BIT];
          if (restart_hit(wr, addr, wdata)) begin
            next_st.load = 1'b1;
          end
        end
        nco_mixer_pkg::REG_OFFSET: next_st.offset  = wdata[17:0];
        nco_mixer_pkg::REG_MIN:    next_st.min_inc = wdata;
        nco_mixer_pkg::REG_MAX:    next_st.max_inc = wdata;
        nco_mixer_pkg::REG_DELTA:  next_st.delta   = wdata[23:0];
        default: ;
      endcase
    end

    // Register reads
    if (rd) begin
      unique case (addr)
        nco_mixer_pkg::REG_CTRL:   next_st.rdata = {29'h0, st.offbin, st.mode};
        nco_mixer_pkg::REG_OFFSET: next_st.rdata = {14'h0, st.offset};
        nco_mixer_pkg::REG_MIN:    next_st.rdata = st.min_inc;
        nco_mixer_pkg::REG_MAX:    next_st.rdata = st.max_inc;
        nco_mixer_pkg::REG_DELTA:  next_st.rdata = {8'h0, st.delta};
        nco_mixer_pkg::REG_INC:    next_st.rdata = st.inc;
        nco_mixer_pkg::REG_PHASE:  next_st.rdata = {st.dir_down, 13'h0, st.acc[32:15]};
        default:                   next_st.rdata = 32'h0;
      endcase
    end

    // Sample capture and coding conversion
    next_st.sample = {sample_input_bus[15] ^ st.offbin, sample_input_bus[14:0]};

    // Sine and cosine from the phase word, angle runs clockwise
    next_st.cos_v = parab_sine(st.acc[32:15] + nco_mixer_pkg::QUARTER_TURN);
    next_st.sin_v = parab_sine(st.acc[32:15]);

    // Mixer with symmetric rounding
    next_st.i_mix = round17(32'($signed(st.sample) * $signed(st.cos_v)));
    next_st.q_mix = round17(32'($signed(st.sample) * $signed(st.sin_v)));

    // Phase generator
    if (st.load) begin
      next_st.load     = restart_hit(wr, addr, wdata);
      next_st.dir_down = 1'b0;
      next_st.acc      = {st.offset, 15'h0};
      next_st.inc      = (st.mode == nco_mixer_pkg::down_chirp_mode) ? st.max_inc : st.min_inc;
    end else begin
      next_st.acc = st.acc - {1'b0, st.inc};
      unique case (st.mode)
        nco_mixer_pkg::constant_tone_mode: begin
          next_st.inc = st.min_inc;
        end
        nco_mixer_pkg::up_chirp_mode: begin
          if (cand_up >= {1'b0, st.max_inc}) begin
            next_st.inc = st.min_inc;
          end else begin
            next_st.inc = cand_up[31:0];
          end
        end
        nco_mixer_pkg::down_chirp_mode: begin
          if (dn_floor) begin
            next_st.inc = st.max_inc;
          end else begin
            next_st.inc = cand_dn[31:0];
          end
        end
        nco_mixer_pkg::up_down_chirp_mode: begin
          if (!st.dir_down) begin
            if (cand_up >= {1'b0, st.max_inc}) begin
              next_st.dir_down = 1'b1;
              next_st.inc      = dn_floor ? st.min_inc : cand_dn[31:0];
            end else begin
              next_st.inc = cand_up[31:0];
            end
          end else begin
            if (dn_floor || cand_dn[31:0] == st.min_inc) begin
              next_st.dir_down = 1'b0;
              next_st.inc      = st.min_inc;
            end else begin
              next_st.inc = cand_dn[31:0];
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= ST_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rdata      = st.rdata;
  assign i_out      = st.i_mix;
  assign q_out      = st.q_mix;
  assign phase_word = st.acc[32:15];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence run_step;
    ce && !st.load && !wr;
  endsequence

  sequence zero_in;
    ce && st.sample == 16'h0 ##1 ce;
  endsequence

  chk_reset_load: assert property (ce && st.load |=> st.acc == {$past(st.offset), 15'h0})
    else $error("accumulator not loaded from offset");

  chk_acc_step: assert property (ce && !st.load |=> st.acc == 33'($past(st.acc) - {1'b0, $past(st.inc)}))
    else $error("accumulator step wrong");

  chk_tone_inc: assert property (run_step and st.mode == nco_mixer_pkg::constant_tone_mode
                                 |=> st.inc == st.min_inc)
    else $error("tone increment not minimum");

  chk_up_below_max: assert property (run_step and st.mode == nco_mixer_pkg::up_chirp_mode
                                     and st.min_inc < st.max_inc |=> st.inc < st.max_inc)
    else $error("up chirp reached maximum");

  chk_up_step: assert property (run_step and st.mode == nco_mixer_pkg::up_chirp_mode
                                and cand_up < {1'b0, st.max_inc} |=> st.inc == $past(cand_up[31:0]))
    else $error("up chirp step wrong");

  chk_down_floor: assert property (run_step and st.mode == nco_mixer_pkg::down_chirp_mode
                                   and st.min_inc <= st.max_inc |=> st.inc >= st.min_inc)
    else $error("down chirp under minimum");

  chk_down_step: assert property (run_step and st.mode == nco_mixer_pkg::down_chirp_mode
                                  and !dn_floor |=> st.inc == $past(cand_dn[31:0]))
    else $error("down chirp step wrong");

  chk_updown_turn: assert property (run_step and st.mode == nco_mixer_pkg::up_down_chirp_mode
                                    and !st.dir_down and cand_up >= {1'b0, st.max_inc} |=> st.dir_down)
    else $error("up/down chirp did not turn");

  chk_offbin_msb: assert property (ce && st.offbin |=> st.sample[15] == !$past(sample_input_bus[15]))
    else $error("offset binary msb not inverted");

  chk_sample_take: assert property (ce && !st.offbin |=> st.sample == $past(sample_input_bus))
    else $error("sample not captured");

  chk_mix_zero: assert property (zero_in |-> i_out == 17'h0 && q_out == 17'h0)
    else $error("zero sample gave nonzero product");

  chk_trig_origin: assert property (ce && phase_word == 18'h0 |=> st.cos_v == nco_mixer_pkg::TRIG_PEAK
                                    && st.sin_v == 16'h0)
    else $error("sinusoid wrong at phase zero");

  chk_read_pulse: assert property (ce && !rd |=> rdata == 32'h0)
    else $error("read data outside answer cycle");

  sequence read_req;
    ce && rd && !wr;
  endsequence

  sequence write_req;
    ce && wr && !rd;
  endsequence

  chk_ce_freeze: assert property (!ce |=> $stable(st))
    else $error("state moved with clock enable low");

  chk_restart_load: assert property (write_req and addr == nco_mixer_pkg::REG_CTRL
                                     and wdata[nco_mixer_pkg::CTRL_RESTART_BIT] |=> st.load)
    else $error("restart request lost");

  chk_load_inc: assert property (ce && st.load |=> st.inc ==
                                 $past(st.mode == nco_mixer_pkg::down_chirp_mode ? st.max_inc : st.min_inc))
    else $error("start increment wrong");

  chk_load_dir: assert property (ce && st.load |=> !st.dir_down)
    else $error("direction not cleared at start");

  chk_up_reload: assert property (run_step and st.mode == nco_mixer_pkg::up_chirp_mode
                                  and cand_up >= {1'b0, st.max_inc} |=> st.inc == $past(st.min_inc))
    else $error("up chirp did not reload minimum");

  chk_down_reload: assert property (run_step and st.mode == nco_mixer_pkg::down_chirp_mode
                                    and dn_floor |=> st.inc == $past(st.max_inc))
    else $error("down chirp did not reload maximum");

  chk_updown_rise: assert property (run_step and st.mode == nco_mixer_pkg::up_down_chirp_mode
                                    and !st.dir_down and cand_up < {1'b0, st.max_inc}
                                    |=> st.inc == $past(cand_up[31:0]) && !st.dir_down)
    else $error("up/down chirp rise wrong");

  chk_updown_fall: assert property (run_step and st.mode == nco_mixer_pkg::up_down_chirp_mode
                                    and st.dir_down and !dn_floor and cand_dn[31:0] != st.min_inc
                                    |=> st.inc == $past(cand_dn[31:0]) && st.dir_down)
    else $error("up/down chirp fall wrong");

  chk_updown_floor: assert property (run_step and st.mode == nco_mixer_pkg::up_down_chirp_mode
                                     and st.dir_down and (dn_floor || cand_dn[31:0] == st.min_inc)
                                     |=> st.inc == $past(st.min_inc) && !st.dir_down)
    else $error("up/down chirp did not restart");

  chk_trig_quarter: assert property (ce && phase_word == nco_mixer_pkg::QUARTER_TURN
                                     |=> st.cos_v == 16'h0 && st.sin_v == nco_mixer_pkg::TRIG_PEAK)
    else $error("sinusoid wrong at quarter turn");

  chk_trig_half: assert property (ce && phase_word == nco_mixer_pkg::HALF_SPAN
                                  |=> st.cos_v == 16'h0 - nco_mixer_pkg::TRIG_PEAK && st.sin_v == 16'h0)
    else $error("sinusoid wrong at half turn");

  chk_trig_three: assert property (ce && phase_word == nco_mixer_pkg::QUARTER_TURN + nco_mixer_pkg::HALF_SPAN
                                   |=> st.cos_v == 16'h0 && st.sin_v == 16'h0 - nco_mixer_pkg::TRIG_PEAK)
    else $error("sinusoid wrong at three quarter turn");

  chk_write_min: assert property (write_req and addr == nco_mixer_pkg::REG_MIN |=> st.min_inc == $past(wdata))
    else $error("minimum write lost");

  chk_write_max: assert property (write_req and addr == nco_mixer_pkg::REG_MAX |=> st.max_inc == $past(wdata))
    else $error("maximum write lost");

  chk_write_offset: assert property (write_req and addr == nco_mixer_pkg::REG_OFFSET
                                     |=> st.offset == $past(wdata[17:0]))
    else $error("offset write lost");

  chk_write_delta: assert property (write_req and addr == nco_mixer_pkg::REG_DELTA
                                    |=> st.delta == $past(wdata[23:0]))
    else $error("delta write lost");

  chk_write_mode: assert property (write_req and addr == nco_mixer_pkg::REG_CTRL
                                   |=> st.mode == $past(wdata[1:0]) && st.offbin == $past(wdata[2]))
    else $error("control write lost");

  chk_read_ctrl: assert property (read_req and addr == nco_mixer_pkg::REG_CTRL
                                  |=> rdata == {29'h0, $past(st.offbin), $past(st.mode)})
    else $error("control read wrong");

  chk_read_offset: assert property (read_req and addr == nco_mixer_pkg::REG_OFFSET
                                    |=> rdata == {14'h0, $past(st.offset)})
    else $error("offset read wrong");

  chk_read_min: assert property (read_req and addr == nco_mixer_pkg::REG_MIN |=> rdata == $past(st.min_inc))
    else $error("minimum read wrong");

  chk_read_max: assert property (read_req and addr == nco_mixer_pkg::REG_MAX |=> rdata == $past(st.max_inc))
    else $error("maximum read wrong");

  chk_read_delta: assert property (read_req and addr == nco_mixer_pkg::REG_DELTA
                                   |=> rdata == {8'h0, $past(st.delta)})
    else $error("delta read wrong");

  chk_read_inc: assert property (read_req and addr == nco_mixer_pkg::REG_INC |=> rdata == $past(st.inc))
    else $error("increment read wrong");

  chk_read_phase: assert property (read_req and addr == nco_mixer_pkg::REG_PHASE
                                   |=> rdata == {$past(st.dir_down), 13'h0, $past(phase_word)})
    else $error("phase read wrong");

  chk_read_unmapped: assert property (read_req and addr > nco_mixer_pkg::REG_PHASE |=> rdata == 32'h0)
    else $error("unmapped read not zero");

endmodule // chirp_nco_quadrature_mixer

// file: verilog/nco_mixer_pkg.sv
// Constants, register map and mode codes for the chirp oscillator and mixer.
// Assumes a single 10 MHz sample clock shared by the source, the bus and the block.
package nco_mixer_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;
  localparam int SAMPLE_W = 16;
  localparam int PHASE_W  = 18;
  localparam int ACC_W    = 33;
  localparam int INC_W    = 32;
  localparam int DELTA_W  = 24;
  localparam int TRIG_W   = 16;
  localparam int MIX_W    = 17;
  localparam int PHASE_LSB = ACC_W - PHASE_W;

  // ==========================================================================
  // Register word addresses
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_OFFSET = 4'h1;
  localparam logic [3:0] REG_MIN    = 4'h2;
  localparam logic [3:0] REG_MAX    = 4'h3;
  localparam logic [3:0] REG_DELTA  = 4'h4;
  localparam logic [3:0] REG_INC    = 4'h5;
  localparam logic [3:0] REG_PHASE  = 4'h6;

  // ==========================================================================
  // Field positions
  localparam int CTRL_MODE_LSB    = 0;
  localparam int CTRL_OFFBIN_BIT  = 2;
  localparam int CTRL_RESTART_BIT = 3;
  localparam int PHASE_DIR_BIT    = 31;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {
    constant_tone_mode,
    up_chirp_mode,
    down_chirp_mode,
    up_down_chirp_mode
  } mode_e;

  // ==========================================================================
  // Reset values
  localparam logic [17:0] RST_OFFSET = 18'h00000;
  localparam logic [31:0] RST_MIN    = 32'h00000000;
  localparam logic [31:0] RST_MAX    = 32'h00000000;
  localparam logic [23:0] RST_DELTA  = 24'h000000;
  localparam logic        RST_OFFBIN = 1'b0;

  // ==========================================================================
  // Sinusoid and rounding constants
  localparam logic [17:0] QUARTER_TURN = 18'h10000;
  localparam logic [17:0] HALF_SPAN    = 18'h20000;
  localparam logic [15:0] TRIG_PEAK    = 16'h4000;
  localparam logic [31:0] RND_POS      = 32'h00004000;
  localparam logic [31:0] RND_NEG      = 32'h00003fff;

endpackage

// file: dv/sample_source.sv
// Behavioural wideband sample source for the mixer's sample bus.
// Assumes the bench sets the level; the output is registered on clk like a converter.
`timescale 1ns/1ps

module sample_source (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] level,
  output logic      [15:0] sample
);
  // ==========================================================================
  // Output register, one new sample each rising edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample <= 16'h0000;
    end else begin
      sample <= level;
    end
  end
endmodule // sample_source

// file: dv/chirp_nco_quadrature_mixer_tb_top.sv
// Self-checking bench for the chirp oscillator and quadrature mixer.
// Assumes one 10 MHz clock, register reads answering one cycle later, ce held high except for a three-cycle drop in the tone test.
`timescale 1ns/1ps

module chirp_nco_quadrature_mixer_tb_top;
  logic        clk;
  logic        rst;
  logic        ce;
  logic [15:0] level;
  logic [15:0] sample;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [16:0] i_out;
  logic [16:0] q_out;
  logic [17:0] phase_word;
  logic [31:0] v [8];
  int          n_fail;
  int          n_checks;

  // ==========================================================================
  // Clock, source and device
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  sample_source src (.clk(clk), .rst(rst), .level(level), .sample(sample));

  chirp_nco_quadrature_mixer dut (.clk(clk), .rst(rst), .ce(ce), .sample_input_bus(sample), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .i_out(i_out), .q_out(q_out), .phase_word(phase_word));

  // ==========================================================================
  // Bus tasks and compare
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_burst(input logic [3:0] a, input int n);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (i == n - 1) rd <= 1'b0;
      #1 v[i] = rdata;
    end
  endtask

  function automatic logic [16:0] mix(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    p = p + ((p < 0) ? 32'sh00003fff : 32'sh00004000);
    return p[31:15];
  endfunction

  // ==========================================================================
  // Tests
  task automatic mode_test(input logic [1:0] m);
    logic [31:0] nx;
    logic        up;
    up = 1'b1;
    wr_reg(nco_mixer_pkg::REG_MIN, (m == 2'h0) ? 32'h00018000 : 32'h00000100);
    wr_reg(nco_mixer_pkg::REG_CTRL, {28'h0000000, 1'b1, 1'b0, m});
    rd_burst(nco_mixer_pkg::REG_CTRL, 1);
    check(v[0], {30'h00000000, m});
    rd_burst(nco_mixer_pkg::REG_INC, 8);
    check(v[0], (m == 2'h0) ? 32'h00018000 : ((m == 2'h2) ? 32'h00000200 : 32'h00000300));
    for (int i = 0; i < 7; i++) begin
      case (m)
        2'h0: nx = v[i];
        2'h1: nx = (v[i] + 32'h100 >= 32'h400) ? 32'h00000100 : v[i] + 32'h100;
        2'h2: nx = (v[i] < 32'h200) ? 32'h00000400 : v[i] - 32'h100;
        default: begin
          if (up && v[i] + 32'h100 < 32'h400) begin
            nx = v[i] + 32'h100;
          end else if (up || v[i] - 32'h100 > 32'h100) begin
            nx = v[i] - 32'h100;
            up = 1'b0;
          end else begin
            nx = 32'h00000100;
            up = 1'b1;
          end
        end
      endcase
      check(v[i + 1], nx);
    end
    if (m == 2'h0) begin
      check(v[0], 32'h00018000);
      @(posedge clk);
      #1 nx = {14'h0000, phase_word};
      repeat (4) begin
        @(posedge clk);
        #1 check({14'h0000, phase_word}, (nx - 32'h3) & 32'h0003ffff);
        nx = {14'h0000, phase_word};
      end
      @(posedge clk);
      ce <= 1'b0;
      #1 nx = {14'h0000, phase_word};
      repeat (3) @(posedge clk);
      #1 check({14'h0000, phase_word}, nx);
      ce <= 1'b1;
    end
    $display("test mode %0d done", m);
  endtask

  task automatic mix_test(input logic [17:0] off, input logic ob, input logic [15:0] lv,
                          input logic [15:0] c, input logic [15:0] s);
    logic [15:0] x;
    x = ob ? (lv ^ 16'h8000) : lv;
    wr_reg(nco_mixer_pkg::REG_MIN, 32'h00000000);
    wr_reg(nco_mixer_pkg::REG_OFFSET, {14'h0000, off});
    wr_reg(nco_mixer_pkg::REG_CTRL, {28'h0000000, 1'b1, ob, 2'h0});
    @(posedge clk);
    level <= lv;
    repeat (5) @(posedge clk);
    #1 check({15'h0000, i_out}, {15'h0000, mix(x, c)});
    check({15'h0000, q_out}, {15'h0000, mix(x, s)});
    rd_burst(nco_mixer_pkg::REG_PHASE, 1);
    check({14'h0000, v[0][17:0]}, {14'h0000, off});
    $display("test mix %h done", lv);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    level = 16'h0000;
    addr = 4'h0;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
    n_fail = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr_reg(4'hf, 32'hffffffff);
    for (int a = 1; a < 5; a++) begin
      rd_burst(4'(a), 1);
      check(v[0], 32'h00000000);
    end
    rd_burst(4'hf, 1);
    check(v[0], 32'h00000000);
    @(posedge clk);
    #1 check(rdata, 32'h00000000);
    wr_reg(nco_mixer_pkg::REG_DELTA, 32'hffffffff);
    rd_burst(nco_mixer_pkg::REG_DELTA, 1);
    check(v[0], 32'h00ffffff);
    $display("test reset done");
    wr_reg(nco_mixer_pkg::REG_DELTA, 32'h00000100);
    wr_reg(nco_mixer_pkg::REG_MAX, 32'h00000400);
    for (int m = 0; m < 4; m++) begin
      mode_test(2'(m));
    end
    mix_test(18'h00000, 1'b0, 16'h1234, 16'h4000, 16'h0000);
    mix_test(18'h00000, 1'b0, 16'hedcc, 16'h4000, 16'h0000);
    mix_test(18'h10000, 1'b0, 16'h1234, 16'h0000, 16'h4000);
    mix_test(18'h00000, 1'b1, 16'h0000, 16'h4000, 16'h0000);
    mix_test(18'h20000, 1'b0, 16'h1234, 16'hc000, 16'h0000);
    mix_test(18'h30000, 1'b0, 16'h1234, 16'h0000, 16'hc000);
    summarize();
  end

  initial begin
    #200000;
    n_fail++;
    summarize();
  end
endmodule // chirp_nco_quadrature_mixer_tb_top
